// >>> adcp_pkg.sv
// Purpose: Shared constants and types for the converter output port
// Assumes: One system clock at 100 MHz; conversion clock sampled as data
// Notes:   Analog levels are carried as unsigned digital magnitudes
package adcp_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADCP_CODE_W = 8;
  localparam int ADCP_LEVEL_W = 12;
  localparam int ADCP_SCALED_W = ADCP_LEVEL_W + ADCP_CODE_W;
  localparam int ADCP_BUF_DEPTH = 2;

  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [ADCP_CODE_W-1:0] ADCP_CODE_ZERO = 8'h00;
  localparam logic [ADCP_CODE_W-1:0] ADCP_CODE_FULL = 8'hFF;
  localparam logic [ADCP_SCALED_W-1:0] ADCP_SCALED_FULL = 20'h000FF;
  localparam logic [ADCP_LEVEL_W-1:0] ADCP_LEVEL_ZERO = 12'h000;
  localparam logic [1:0] ADCP_WARM_CYCLES = 2'h2;
  localparam logic [1:0] ADCP_WARM_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int ADCP_CLK_MHZ = 100;
  localparam int ADCP_MAX_RATE_MSPS = 30;
  localparam int ADCP_MIN_CONV_PERIOD_CYC =
    (ADCP_CLK_MHZ + ADCP_MAX_RATE_MSPS - 1) / ADCP_MAX_RATE_MSPS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [ADCP_CODE_W-1:0] code;
  } adcp_stage_type;

  localparam adcp_stage_type ADCP_STAGE_RESET = '{valid: 1'b0, code: 8'h00};

endpackage

// >>> adcp_buf.sv
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Synchronous active-low reset
// Notes:   Read data come straight from the storage registers
`timescale 1ns/1ns
module adcp_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW-1:0] PTR_ZERO = '0;
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  localparam logic [CW-1:0] CNT_ZERO = '0;
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [AW-1:0] wr_ptr_next = (wr_ptr_q == PTR_LAST) ? PTR_ZERO : wr_ptr_q + AW'(1);
  wire [AW-1:0] rd_ptr_next = (rd_ptr_q == PTR_LAST) ? PTR_ZERO : rd_ptr_q + AW'(1);

  assign in_ready = (count_q != CNT_FULL);
  assign out_valid = (count_q != CNT_ZERO);
  assign out_data = mem_q[rd_ptr_q];

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      wr_ptr_q <= PTR_ZERO;
      rd_ptr_q <= PTR_ZERO;
      count_q <= CNT_ZERO;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= wr_ptr_next;
      end
      if (pop)
      begin
        rd_ptr_q <= rd_ptr_next;
      end
      if (push && !pop)
      begin
        count_q <= count_q + CNT_ONE;
      end
      else if (pop && !push)
      begin
        count_q <= count_q - CNT_ONE;
      end
    end
  end

endmodule

// >>> adcp_port.sv
// Purpose: Digital side of an 8-bit sampling converter with a pipelined output port
// Assumes: conv_clk and out_en_b are synchronous to clk_sys; levels are unsigned magnitudes
// Notes:   Samples on conv_clk falls, updates the output word on conv_clk rises
//
// How it works
// - A sample is taken on each falling edge of the conversion clock.
// - A sample's word reaches the outputs two and a half clock cycles later.
// - Conversion runs while the conversion clock toggles and stops when it stops.
// - With the output enable low the eight data pins are driven.
// - With the output enable high the pins float; conversion carries on.
// - Inputs below the bottom reference give an all-zero word.
// - Inputs above the top reference give the all-ones word.
// - A fresh word appears every clock cycle, lagging by the fixed delay.
// - Output data change only after rising edges of the conversion clock.
// - Each conversion yields eight bits, up to thirty million samples per second.
`timescale 1ns/1ns
module adcp_port
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Conversion clock and enable from the capture side
  input wire logic conv_clk,
  input wire logic out_en_b,
  // Analog levels as magnitudes
  input wire logic [adcp_pkg::ADCP_LEVEL_W-1:0] analog_sample_input,
  input wire logic [adcp_pkg::ADCP_LEVEL_W-1:0] ref_top_level,
  input wire logic [adcp_pkg::ADCP_LEVEL_W-1:0] ref_bottom_level,
  // Output pins
  output logic [adcp_pkg::ADCP_CODE_W-1:0] data_o,
  output logic data_oe,
  // Status
  output logic conv_ready,
  output logic warm_done
);
  import adcp_pkg::*;

  // ----------------------------------------------------------------
  // Conversion clock edges
  // ----------------------------------------------------------------
  logic conv_prev_q;
  wire conv_fall = conv_prev_q && !conv_clk;
  wire conv_rise = !conv_prev_q && conv_clk;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      conv_prev_q <= 1'b0;
    end
    else
    begin
      conv_prev_q <= conv_clk;
    end
  end

  // ----------------------------------------------------------------
  // Quantiser
  // ----------------------------------------------------------------
  wire in_below = analog_sample_input < ref_bottom_level;
  wire in_above = analog_sample_input > ref_top_level;
  wire [ADCP_LEVEL_W-1:0] in_diff = analog_sample_input - ref_bottom_level;
  wire [ADCP_LEVEL_W-1:0] ref_span = ref_top_level - ref_bottom_level;
  wire [ADCP_SCALED_W-1:0] scaled =
    {in_diff, ADCP_CODE_ZERO} - {{ADCP_CODE_W{1'b0}}, in_diff};
  wire span_zero = (ref_span == ADCP_LEVEL_ZERO);
  wire [ADCP_SCALED_W-1:0] quot =
    span_zero ? ADCP_SCALED_FULL : scaled / {{ADCP_CODE_W{1'b0}}, ref_span};
  wire [ADCP_CODE_W-1:0] lin_code =
    (quot > ADCP_SCALED_FULL) ? ADCP_CODE_FULL : quot[ADCP_CODE_W-1:0];
  wire [ADCP_CODE_W-1:0] sample_code =
    in_below ? ADCP_CODE_ZERO :
    in_above ? ADCP_CODE_FULL : lin_code;

  // ----------------------------------------------------------------
  // Sample buffer
  // ----------------------------------------------------------------
  logic buf_valid;
  logic [ADCP_CODE_W-1:0] buf_data;
  logic buf_in_ready;

  adcp_buf #(
    .WIDTH(ADCP_CODE_W),
    .DEPTH(ADCP_BUF_DEPTH)
  )
  u_buf
  (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .in_valid(conv_fall),
    .in_ready(buf_in_ready),
    .in_data(sample_code),
    .out_valid(buf_valid),
    .out_ready(conv_rise),
    .out_data(buf_data)
  );

  assign conv_ready = buf_in_ready;

  // ----------------------------------------------------------------
  // Output pipeline
  // ----------------------------------------------------------------
  adcp_stage_type stage1_q;
  adcp_stage_type stage2_q;
  logic [ADCP_CODE_W-1:0] out_q;
  wire adcp_stage_type stage1_d = '{valid: buf_valid, code: buf_data};

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      stage1_q <= ADCP_STAGE_RESET;
      stage2_q <= ADCP_STAGE_RESET;
      out_q <= ADCP_CODE_ZERO;
    end
    else if (conv_rise)
    begin
      stage1_q <= stage1_d;
      stage2_q <= stage1_q;
      if (stage2_q.valid)
      begin
        out_q <= stage2_q.code;
      end
    end
  end

  // ----------------------------------------------------------------
  // Warm-up after start
  // ----------------------------------------------------------------
  logic [1:0] warm_q;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      warm_q <= ADCP_WARM_RESET;
    end
    else if (conv_rise && warm_q != ADCP_WARM_CYCLES)
    begin
      warm_q <= warm_q + 2'h1;
    end
  end

  assign warm_done = (warm_q == ADCP_WARM_CYCLES);

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  assign data_o = out_q;
  assign data_oe = !out_en_b;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  a_fall_push_taken:
    assert property (conv_fall && buf_in_ready |=> buf_valid)
    else $error("falling edge sample not taken");

  a_pipe_latency:
    assert property (conv_rise && stage2_q.valid |=> out_q == $past(stage2_q.code))
    else $error("output word does not follow pipeline");

  a_idle_stable:
    assert property (!conv_rise |=> $stable(out_q) && $stable(stage1_q))
    else $error("pipeline moved without conversion clock");

  a_oe_drives:
    assert property (!out_en_b |-> data_oe && data_o == out_q)
    else $error("pins not driven while enabled");

  a_oe_floats:
    assert property (out_en_b && conv_rise && stage2_q.valid
                     |-> !data_oe ##1 (out_q == $past(stage2_q.code)))
    else $error("disable state wrong or conversion halted");

  a_clamp_low:
    assert property (conv_fall && in_below && buf_in_ready && !buf_valid
                     |=> buf_data == ADCP_CODE_ZERO)
    else $error("low input not clamped to zero");

  a_clamp_high:
    assert property (conv_fall && in_above && buf_in_ready && !buf_valid
                     |=> buf_data == ADCP_CODE_FULL)
    else $error("high input not clamped to all ones");

  a_rise_only_update:
    assert property ($changed(out_q) |-> $past(conv_rise))
    else $error("output changed away from a rising edge");

  a_warm_count:
    assert property (conv_rise && warm_q == ADCP_WARM_RESET
                     |=> !warm_done ##0 (!conv_rise)[*1] ##0 warm_q == 2'h1)
    else $error("warm-up count wrong");

endmodule

// >>> adcp_host.sv
// Purpose: Capture-side model driving the conversion clock and output enable
// Assumes: Half period given in system clock cycles, at least one
// Notes:   The conversion clock stops low while run is low
`timescale 1ns/1ns
module adcp_host
(
  // Clock
  input wire logic clk_sys,
  // Control from the bench
  input wire logic run,
  input wire logic [3:0] half_cyc,
  input wire logic oe_req,
  // Lines to the converter
  output logic conv_clk,
  output logic out_en_b
);
  logic [3:0] cnt_q;

  // ----------------------------------------------------------------
  // Clock and enable generation
  // ----------------------------------------------------------------
  initial
  begin
    conv_clk = 1'b0;
    out_en_b = 1'b1;
    cnt_q = 4'h0;
  end

  always @(posedge clk_sys)
  begin
    out_en_b <= #1 !oe_req;
    if (!run)
    begin
      conv_clk <= #1 1'b0;
      cnt_q <= 4'h0;
    end
    else if (cnt_q == half_cyc - 4'h1)
    begin
      conv_clk <= #1 !conv_clk;
      cnt_q <= 4'h0;
    end
    else
      cnt_q <= cnt_q + 4'h1;
  end
endmodule

// >>> tb_adc_pipelined_output_port.sv
// Purpose: Self-checking bench for the converter output port
// Assumes: Host model makes the conversion clock from the system clock
// Notes:   A reference pipeline predicts every output word
`timescale 1ns/1ns
module tb_adc_pipelined_output_port;
  import adcp_pkg::*;
  logic clk_sys, rst_b, run, oe_req, conv_clk, out_en_b;
  logic data_oe, conv_ready, warm_done, pend1, prev;
  logic [3:0] half_cyc;
  logic [11:0] ain, rtop, rbot;
  logic [7:0] data_o, held, q[$];
  logic [8:0] p0, p1, p2;
  wire [7:0] pins = data_oe ? data_o : 8'hZZ;
  int n_mismatch = 0;
  int tests_run = 0;

  adcp_host u_adcp_host (.clk_sys(clk_sys), .run(run), .half_cyc(half_cyc),
    .oe_req(oe_req), .conv_clk(conv_clk), .out_en_b(out_en_b));
  adcp_port u_adcp_port (.clk_sys(clk_sys), .rst_b(rst_b), .conv_clk(conv_clk),
    .out_en_b(out_en_b), .analog_sample_input(ain), .ref_top_level(rtop),
    .ref_bottom_level(rbot), .data_o(data_o), .data_oe(data_oe),
    .conv_ready(conv_ready), .warm_done(warm_done));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [11:0] seen, input logic [11:0] expv);
    tests_run++;
    if (seen !== expv)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, expv);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  function automatic logic [7:0] quant(input logic [11:0] v, t, b);
    logic [19:0] c;
    if (v < b) return ADCP_CODE_ZERO;
    if (v > t || t == b) return ADCP_CODE_FULL;
    c = ((v - b) * 20'h000FF) / (t - b);
    return c[7:0];
  endfunction

  task automatic complete_run;
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Reference pipeline and stream monitor
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      prev = 1'b0;
      q.delete();
      {p0, p1, p2} = '0;
      pend1 = 1'b0;
    end
    else
    begin
      if (prev && !conv_clk) q.push_back(quant(ain, rtop, rbot));
      if (!prev && conv_clk)
      begin
        p2 = p1;
        p1 = p0;
        p0 = (q.size() > 0) ? {1'b1, q.pop_front()} : 9'h000;
      end
      pend1 = !prev && conv_clk && p2[8];
      prev = conv_clk;
    end
  end

  always @(negedge clk_sys)
    if (!rst_b)
      held = 8'h00;
    else if (pend1)
    begin
      check(data_o, p2[7:0]);
      held = p2[7:0];
    end
    else
      check(data_o, held);

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_codes;
    logic [11:0] vals[8] = '{12'h000, 12'h063, 12'h064, 12'h0E5,
                             12'h263, 12'h463, 12'h464, 12'hFFF};
    rbot = 12'h064;
    rtop = 12'h463;
    run = 1'b1;
    foreach (vals[i])
    begin
      ain = vals[i];
      step(4);
    end
    step(16);
  endtask

  task automatic t_flat;
    rtop = 12'h1F4;
    rbot = 12'h1F4;
    ain = 12'h1F4;
    step(20);
    @(negedge clk_sys);
    check(data_o, 8'hFF);
    step(1);
    ain = 12'h1F3;
    step(20);
    @(negedge clk_sys);
    check(data_o, 8'h00);
    step(1);
  endtask

  task automatic t_slow;
    rbot = 12'h000;
    rtop = 12'hFFF;
    half_cyc = 4'h3;
    for (int i = 0; i < 6; i++)
    begin
      ain = 12'h155 * i[11:0];
      step(6);
    end
    half_cyc = 4'h2;
    step(16);
  endtask

  task automatic t_stop;
    run = 1'b0;
    ain = 12'h300;
    step(24);
    run = 1'b1;
    step(24);
  endtask

  task automatic t_oe;
    oe_req = 1'b0;
    ain = 12'h9AB;
    step(2);
    @(negedge clk_sys);
    check(data_oe, 1'b0);
    check(pins, 8'hZZ);
    step(16);
    oe_req = 1'b1;
    step(1);
    @(negedge clk_sys);
    check(data_oe, 1'b1);
    check(pins, p2[7:0]);
    check(conv_ready, 1'b1);
    step(1);
  endtask

  task automatic t_warm;
    run = 1'b0;
    step(2);
    rst_b = 1'b0;
    step(6);
    rst_b = 1'b1;
    @(negedge clk_sys);
    check(warm_done, 1'b0);
    check(data_o, 8'h00);
    step(1);
    run = 1'b1;
    step(12);
    check(warm_done, 1'b1);
    step(16);
  endtask

  // ----------------------------------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial
  begin
    {rst_b, run, oe_req, pend1, prev} = 5'h04;
    half_cyc = 4'h2;
    {ain, rtop, rbot, p0, p1, p2, held} = '0;
    step(6);
    rst_b = 1'b1;
    t_codes;
    t_flat;
    t_slow;
    t_stop;
    t_oe;
    t_warm;
    complete_run;
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    complete_run;
  end
endmodule
